// >>> src/jbs_pkg.sv
// Purpose: shared constants and types for the junction box stop supervisor
// Assumes: core_clk at 10 MHz
// Notes:   bar colour codes are 3 bits {red, green, blue}
package jbs_pkg;

	localparam int unsigned CLK_HZ          = 10_000_000;
	// times in milliseconds
	localparam int unsigned COUNTDOWN_MS    = 10_000;
	localparam int unsigned SEGMENT_MS      = 1_670;
	localparam int unsigned BLINK_MS        = 500;
	localparam int unsigned TICK_MS         = 10;
	// prescaler: one tick every TICK_MS
	localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned COUNTDOWN_TICKS = COUNTDOWN_MS / TICK_MS;
	localparam int unsigned SEGMENT_TICKS   = SEGMENT_MS / TICK_MS;
	localparam int unsigned BLINK_TICKS     = BLINK_MS / TICK_MS;

	localparam int unsigned NUM_SEG         = 6;
	localparam int unsigned TICK_W          = 17;
	localparam int unsigned CNT_W           = 10;

	// bar colours
	localparam logic [2:0] COL_OFF    = 3'h0;
	localparam logic [2:0] COL_GREEN  = 3'h2;
	localparam logic [2:0] COL_WHITE  = 3'h7;
	localparam logic [2:0] COL_YELLOW = 3'h6;
	localparam logic [2:0] COL_RED    = 3'h4;
	localparam logic [2:0] COL_ERROR  = 3'h5;
	localparam logic [NUM_SEG-1:0] SEG_ALL  = 6'h3F;
	localparam logic [NUM_SEG-1:0] SEG_NONE = 6'h00;
	localparam logic [NUM_SEG-1:0] SEG_ERR  = 6'h2A;

	typedef enum logic [7:0] {
		ST_START    = 8'h01,
		ST_NORMAL   = 8'h02,
		ST_BRIDGE   = 8'h04,
		ST_STOP     = 8'h08,
		ST_ERROR    = 8'h10,
		ST_COUNT    = 8'h20,
		ST_SAFE     = 8'h40,
		ST_IDLE     = 8'h80
	} jbs_state_t;

endpackage : jbs_pkg

// >>> src/jbs_supervisor.sv
// Purpose: stop supervisor state machine, indicators and relay drive
// Assumes: pins synchronised here; retained memory is an external store
// Notes:   relay and all indicators are dark unless power_good
//
// Overview of operation
// R1 - power lamp green when supply present and startup fault free
// R2 - lamp-button indicator green while terminal has illuminated stop button
// R3 - network indicator green while network link is up
// R4 - bar solid green with terminal attached and stop not pressed
// R5 - bar solid white with bridge plug attached, no terminal
// R6 - bar blinks white when nothing attached and no countdown
// R7 - detach starts ten-second countdown, bar solid yellow
// R8 - one segment off, right to left, every 1.67 seconds
// R9 - countdown expiry: safe mode, stop circuit open, bar blinks yellow
// R10 - stop pressed: safe mode, bar solid red
// R11 - bar shows status only while power indicator is green
// R12 - relays closed only by active drive
// R13 - at power loss, store inputs and stop state in retained memory
// R14 - at power-up, read retained states to choose starting state
// R15 - normal state with terminal attached and stop not activated
// R16 - bridge-active state while bridge plug attached
// R17 - stop state once terminal stop button activated
// R18 - error when retained stop set but terminal stop reads clear
// R19 - error clears only after stop activate then release
// R20 - stop input bypassed during countdown until valid reattach
// R21 - stop must be released before returning to normal
// R22 - timing from prescaled tick; fixed blink period
// R23 - distinct bar pattern for internal error
module jbs_supervisor
	import jbs_pkg::*;
(
	input  wire logic                       core_clk,
	input  wire logic                       reset,
	input  wire logic                       supply_ok,
	input  wire logic                       startup_fault,
	input  wire logic                       power_fail,
	input  wire logic                       term_present,
	input  wire logic                       term_lamp_button,
	input  wire logic                       bridge_present,
	input  wire logic                       stop_pressed,
	input  wire logic                       net_link,
	input  wire logic                       ret_valid,
	input  wire logic                       ret_term,
	input  wire logic                       ret_bridge,
	input  wire logic                       ret_stop,
	output logic                            power_led,
	output logic                            lamp_led,
	output logic                            net_led,
	output logic [jbs_pkg::NUM_SEG-1:0]     bar_seg,
	output logic [2:0]                      bar_color,
	output logic                            relay_drive,
	output logic                            ret_wr,
	output logic                            ret_wr_term,
	output logic                            ret_wr_bridge,
	output logic                            ret_wr_stop
);
	import jbs_pkg::*;

	//----------------------------------------------------------------
	// input synchronisers
	//----------------------------------------------------------------
	localparam int unsigned NIN = 12;
	logic [NIN-1:0] pin_raw;
	logic [NIN-1:0] sync1;
	logic [NIN-1:0] sync2;
	assign pin_raw = {supply_ok, startup_fault, power_fail, term_present,
		term_lamp_button, bridge_present, stop_pressed, net_link, ret_valid,
		ret_term, ret_bridge, ret_stop};

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= pin_raw;
			sync2 <= sync1;
		end
	end

	logic s_supply, s_fault, s_pfail, s_term, s_lamp, s_bridge, s_stop, s_net, s_rvalid;
	logic s_rterm, s_rbridge, s_rstop;
	assign {s_supply, s_fault, s_pfail, s_term, s_lamp, s_bridge, s_stop, s_net,
		s_rvalid, s_rterm, s_rbridge, s_rstop} = sync2;

	//----------------------------------------------------------------
	// tick prescaler and timers
	//----------------------------------------------------------------
	logic [TICK_W-1:0] pre;
	logic [TICK_W-1:0] next_pre;
	logic              tick;
	logic              next_tick;
	logic [CNT_W-1:0]  cd;
	logic [CNT_W-1:0]  next_cd;
	logic [CNT_W-1:0]  bl;
	logic [CNT_W-1:0]  next_bl;
	logic              blink;
	logic              next_blink;

	jbs_state_t state;
	jbs_state_t next_state;
	logic       err_seen_press;
	logic       next_err_seen_press;
	logic       pg;
	logic       next_pg;
	logic       saved;
	logic       next_saved;

	function automatic logic [NUM_SEG-1:0] seg_mask(input logic [CNT_W-1:0] elapsed);
		logic [NUM_SEG-1:0] m;
		m = SEG_ALL;
		for (int i = 0; i < NUM_SEG; i++) begin
			if (elapsed >= CNT_W'((i + 1) * SEGMENT_TICKS))
				m[i] = 1'b0;
		end
		return m;
	endfunction

	// R22 - prescaled tick, fixed blink
	always_comb begin
		next_tick  = 1'b0;
		next_pre   = pre + TICK_W'(1);
		if (pre == TICK_W'(TICK_CYCLES - 1)) begin
			next_pre  = '0;
			next_tick = 1'b1;
		end
		next_bl    = bl;
		next_blink = blink;
		if (tick) begin
			if (bl == CNT_W'(BLINK_TICKS - 1)) begin
				next_bl    = '0;
				next_blink = ~blink;
			end else begin
				next_bl = bl + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pre   <= '0;
			tick  <= 1'b0;
			bl    <= '0;
			blink <= 1'b0;
		end else begin
			pre   <= next_pre;
			tick  <= next_tick;
			bl    <= next_bl;
			blink <= next_blink;
		end
	end

	//----------------------------------------------------------------
	// supervisor state machine
	//----------------------------------------------------------------
	logic term_ok;
	assign term_ok = s_term && !s_stop;

	always_comb begin
		next_state          = state;
		next_cd             = cd;
		next_err_seen_press = err_seen_press;
		// R1 - power good after clean startup
		next_pg             = s_supply && !s_fault && !s_pfail;
		next_saved          = saved;
		case (state)
			ST_START: begin
				next_cd = '0;
				// no stale press carried into a new error
				next_err_seen_press = 1'b0;
				// R14 - retained states pick start
				if (pg && s_rvalid) begin
					// R18 - retained stop vs clear button
					if (s_rstop && s_term && !s_stop)
						next_state = ST_ERROR;
					else if (s_term && s_stop)
						next_state = ST_STOP;
					else if (s_term)
						next_state = ST_NORMAL;
					else if (s_bridge)
						next_state = ST_BRIDGE;
					else if (s_rterm || s_rbridge)
						next_state = ST_COUNT;
					else
						next_state = ST_IDLE;
				end
			end
			ST_NORMAL: begin
				// R17 - stop pressed
				if (s_term && s_stop)
					next_state = ST_STOP;
				// R7 - detach starts countdown
				else if (!s_term) begin
					next_state = ST_COUNT;
					next_cd    = '0;
				end
			end
			ST_BRIDGE: begin
				if (s_term)
					next_state = s_stop ? ST_STOP : ST_NORMAL;
				else if (!s_bridge) begin
					next_state = ST_COUNT;
					next_cd    = '0;
				end
			end
			ST_STOP: begin
				// R21 - release before normal
				if (!s_term) begin
					next_state = ST_COUNT;
					next_cd    = '0;
				end else if (!s_stop)
					next_state = ST_NORMAL;
			end
			ST_ERROR: begin
				// R19 - press then release clears
				if (s_term && s_stop)
					next_err_seen_press = 1'b1;
				else if (s_term && err_seen_press) begin
					next_err_seen_press = 1'b0;
					next_state          = ST_NORMAL;
				end
			end
			ST_COUNT: begin
				// R20 - stop bypassed until valid plug
				if (term_ok)
					next_state = ST_NORMAL;
				else if (s_bridge && !s_term)
					next_state = ST_BRIDGE;
				// R9 - timeout to safe
				else if (cd >= CNT_W'(COUNTDOWN_TICKS))
					next_state = ST_SAFE;
				else if (tick)
					next_cd = cd + CNT_W'(1);
			end
			ST_SAFE, ST_IDLE: begin
				// R15 - valid terminal, normal
				if (term_ok)
					next_state = ST_NORMAL;
				else if (s_term)
					next_state = ST_STOP;
				// R16 - bridge plug active
				else if (s_bridge)
					next_state = ST_BRIDGE;
			end
			default: next_state = ST_START;
		endcase
		// R13 - save once at power loss
		if (s_pfail)
			next_saved = 1'b1;
		else if (!s_pfail)
			next_saved = 1'b0;
		if (!pg)
			next_state = ST_START;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state          <= ST_START;
			cd             <= '0;
			err_seen_press <= 1'b0;
			pg             <= 1'b0;
			saved          <= 1'b0;
		end else begin
			state          <= next_state;
			cd             <= next_cd;
			err_seen_press <= next_err_seen_press;
			pg             <= next_pg;
			saved          <= next_saved;
		end
	end

	//----------------------------------------------------------------
	// output decode, registered
	//----------------------------------------------------------------
	logic [NUM_SEG-1:0] next_seg;
	logic [2:0]         next_col;
	logic               next_relay;
	logic               next_wr;
	logic               stop_now;

	assign stop_now = (state == ST_STOP) || (state == ST_SAFE) || (state == ST_ERROR);

	always_comb begin
		next_seg   = SEG_ALL;
		next_col   = COL_OFF;
		// R12 - relay only by active drive
		next_relay = pg && (state == ST_NORMAL || state == ST_BRIDGE || state == ST_COUNT
			|| state == ST_IDLE);
		// R13 - one write pulse on power fail edge
		next_wr    = s_pfail && !saved;
		case (state)
			// R4 - solid green
			ST_NORMAL: next_col = COL_GREEN;
			// R5 - solid white
			ST_BRIDGE: next_col = COL_WHITE;
			// R6 - blinking white
			ST_IDLE:   next_col = blink ? COL_WHITE : COL_OFF;
			// R10 - solid red
			ST_STOP:   next_col = COL_RED;
			// R8 - segments drop right to left
			ST_COUNT: begin
				next_col = COL_YELLOW;
				next_seg = seg_mask(cd);
			end
			ST_SAFE:   next_col = blink ? COL_YELLOW : COL_OFF;
			// R23 - distinct error pattern
			ST_ERROR: begin
				next_col = COL_ERROR;
				next_seg = SEG_ERR;
			end
			default: next_seg = SEG_NONE;
		endcase
		// R11 - bar dark without power
		if (!pg || next_col == COL_OFF) begin
			next_seg = SEG_NONE;
			next_col = COL_OFF;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			power_led     <= 1'b0;
			lamp_led      <= 1'b0;
			net_led       <= 1'b0;
			bar_seg       <= SEG_NONE;
			bar_color     <= COL_OFF;
			relay_drive   <= 1'b0;
			ret_wr        <= 1'b0;
			ret_wr_term   <= 1'b0;
			ret_wr_bridge <= 1'b0;
			ret_wr_stop   <= 1'b0;
		end else begin
			power_led     <= pg;
			// R2 - lamp button indicator
			lamp_led      <= pg && s_term && s_lamp;
			// R3 - network indicator
			net_led       <= pg && s_net;
			bar_seg       <= next_seg;
			bar_color     <= next_col;
			relay_drive   <= next_relay;
			ret_wr        <= next_wr;
			ret_wr_term   <= s_term;
			ret_wr_bridge <= s_bridge;
			ret_wr_stop   <= stop_now;
		end
	end

	//----------------------------------------------------------------
	// assertions
	//----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	a_relay_open_stop: assert property ((state == ST_STOP) |=> !relay_drive) // R12
		else $error("relay driven in stop state");
	a_power_led_follow: assert property (!pg |=> !power_led) // R1
		else $error("power led lit without power");
	a_bar_dark_nopwr: assert property (!pg |=> bar_color == COL_OFF) // R11
		else $error("bar lit without power");
	a_green_normal: assert property ((state == ST_NORMAL && pg) |=> bar_color == COL_GREEN) // R4
		else $error("normal not green");
	a_white_bridge: assert property ((state == ST_BRIDGE && pg) |=> bar_color == COL_WHITE) // R5
		else $error("bridge not white");
	a_red_stop: assert property ((state == ST_STOP && pg) |=> bar_color == COL_RED) // R10
		else $error("stop not red");
	a_count_timeout: assert property ((state == ST_COUNT && cd >= CNT_W'(COUNTDOWN_TICKS)
		&& !term_ok && !s_bridge && pg) |=> state == ST_SAFE) // R9
		else $error("countdown did not reach safe");
	a_err_press_first: assert property ((state == ST_ERROR && !err_seen_press && pg)
		|=> state != ST_NORMAL) // R19
		else $error("error cleared without press");
	a_stop_to_normal: assert property ((state == ST_STOP && s_stop && pg)
		|=> state != ST_NORMAL) // R21
		else $error("stop left while pressed");
	a_count_start: assert property ((state == ST_NORMAL && !s_term && pg)
		|=> state == ST_COUNT && cd == '0) // R7
		else $error("detach did not start countdown");

	c_count_safe: cover property (state == ST_COUNT ##1 state == ST_SAFE);
	c_error_clear: cover property (state == ST_ERROR ##1 state == ST_NORMAL);
	c_stop_normal: cover property (state == ST_STOP ##1 state == ST_NORMAL);
	c_ret_write: cover property (ret_wr);

endmodule // jbs_supervisor

// >>> dv/jbs_plug_model.sv
// Purpose: far-side model of the connector: operator terminal or bridge plug
// Assumes: bench selects what is plugged in and the button position
// Notes:   open stop contacts read as activated when no terminal is fitted
module jbs_plug_model (
	input  wire logic attach_term,
	input  wire logic attach_bridge,
	input  wire logic has_lamp,
	input  wire logic push,
	output logic      term_present,
	output logic      term_lamp_button,
	output logic      bridge_present,
	output logic      stop_pressed
);
	timeunit 1ns;
	timeprecision 1ns;

	assign term_present     = attach_term;
	assign bridge_present   = attach_bridge & ~attach_term;
	// lamp only with a fitted terminal
	assign term_lamp_button = attach_term & has_lamp;
	// unplugged contacts are open, read as activated
	assign stop_pressed     = attach_term ? push : 1'b1;
endmodule // jbs_plug_model

// >>> dv/testbench.sv
// Purpose: self-checking bench for the stop supervisor
// Assumes: 10 s countdown and blink periods too long to run out here
// Notes:   checks countdown start, not segment drop or expiry
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import jbs_pkg::*;

	logic core_clk, reset, supply_ok, startup_fault, power_fail, net_link;
	logic ret_valid, ret_term, ret_bridge, ret_stop;
	logic at_term, at_bridge, has_lamp, push;
	logic term_present, term_lamp_button, bridge_present, stop_pressed;
	logic power_led, lamp_led, net_led, relay_drive;
	logic ret_wr, ret_wr_term, ret_wr_bridge, ret_wr_stop;
	logic [NUM_SEG-1:0] bar_seg;
	logic [2:0]         bar_color;
	int miscompares = 0;
	int cmp_count = 0;

	typedef struct packed {
		logic t, l, b, p, n, e_lamp, e_net, e_relay;
		logic [2:0] e_col;
	} jbs_row_t;
	jbs_row_t rows [7] = '{
		'{1, 1, 0, 0, 1, 1, 1, 1, COL_GREEN},
		'{1, 0, 0, 0, 0, 0, 0, 1, COL_GREEN},
		'{0, 0, 0, 0, 1, 0, 1, 1, COL_YELLOW},
		'{0, 0, 1, 0, 1, 0, 1, 1, COL_WHITE},
		'{1, 1, 0, 0, 1, 1, 1, 1, COL_GREEN},
		'{1, 1, 0, 1, 1, 1, 1, 0, COL_RED},
		'{1, 1, 0, 0, 1, 1, 1, 1, COL_GREEN}
	};

	jbs_plug_model jbs_plug_model_i (.attach_term(at_term), .attach_bridge(at_bridge),
		.has_lamp(has_lamp), .push(push), .term_present(term_present),
		.term_lamp_button(term_lamp_button), .bridge_present(bridge_present),
		.stop_pressed(stop_pressed));

	jbs_supervisor jbs_supervisor_i (.core_clk(core_clk), .reset(reset),
		.supply_ok(supply_ok), .startup_fault(startup_fault), .power_fail(power_fail),
		.term_present(term_present), .term_lamp_button(term_lamp_button),
		.bridge_present(bridge_present), .stop_pressed(stop_pressed), .net_link(net_link),
		.ret_valid(ret_valid), .ret_term(ret_term), .ret_bridge(ret_bridge),
		.ret_stop(ret_stop), .power_led(power_led), .lamp_led(lamp_led), .net_led(net_led),
		.bar_seg(bar_seg), .bar_color(bar_color), .relay_drive(relay_drive),
		.ret_wr(ret_wr), .ret_wr_term(ret_wr_term), .ret_wr_bridge(ret_wr_bridge),
		.ret_wr_stop(ret_wr_stop));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_vec({7'h00, got}, {7'h00, exp});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic do_reset();
		reset = 1'b1;
		repeat (10) @(posedge core_clk);
		@(negedge core_clk);
		reset = 1'b0;
		cyc(12);
	endtask

	task automatic store_check(input logic [7:0] exp);
		int k;
		power_fail = 1'b1;
		k = 0;
		while (ret_wr !== 1'b1 && k < 20) begin
			@(posedge core_clk);
			#1;
			k++;
		end
		chk_bit(ret_wr, 1'b1);
		chk_vec({5'h00, ret_wr_term, ret_wr_bridge, ret_wr_stop}, exp);
		@(posedge core_clk);
		#1;
		chk_bit(ret_wr, 1'b0);
		cyc(8);
	endtask

	task automatic conclude();
		$display("compares=%0d miscompares=%0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		cyc(5000);
		miscompares++;
		conclude();
	end

	initial begin
		{reset, power_fail, net_link, ret_term, ret_bridge, ret_stop} = 6'h20;
		{at_term, at_bridge, has_lamp, push} = 4'h0;
		supply_ok = 1'b1;
		startup_fault = 1'b1;
		ret_valid = 1'b1;
		do_reset();
		chk_bit(power_led, 1'b0);
		chk_vec(8'(bar_color), 8'(COL_OFF));
		chk_bit(relay_drive, 1'b0);
		startup_fault = 1'b0;
		do_reset();
		chk_bit(power_led, 1'b1);
		chk_bit(bar_color === COL_WHITE || bar_color === COL_OFF, 1'b1);
		for (int i = 0; i < 7; i++) begin
			{at_term, has_lamp, at_bridge, push, net_link} =
				{rows[i].t, rows[i].l, rows[i].b, rows[i].p, rows[i].n};
			cyc(12);
			chk_bit(lamp_led, rows[i].e_lamp);
			chk_bit(net_led, rows[i].e_net);
			chk_vec(8'(bar_color), 8'(rows[i].e_col));
			chk_vec(8'(bar_seg), 8'(SEG_ALL));
			chk_bit(relay_drive, rows[i].e_relay);
		end
		// store on power loss
		store_check(8'h04);
		chk_bit(relay_drive, 1'b0);
		// retained stop against a released button
		power_fail = 1'b0;
		{ret_term, ret_stop} = 2'h3;
		do_reset();
		chk_vec(8'(bar_color), 8'(COL_ERROR));
		chk_vec(8'(bar_seg), 8'(SEG_ERR));
		chk_bit(relay_drive, 1'b0);
		push = 1'b1;
		cyc(12);
		chk_bit(relay_drive, 1'b0);
		push = 1'b0;
		cyc(12);
		chk_vec(8'(bar_color), 8'(COL_GREEN));
		chk_bit(relay_drive, 1'b1);
		// store while stopped, restart with the button still pressed
		push = 1'b1;
		cyc(12);
		store_check(8'h05);
		power_fail = 1'b0;
		do_reset();
		chk_vec(8'(bar_color), 8'(COL_RED));
		chk_bit(relay_drive, 1'b0);
		push = 1'b0;
		cyc(12);
		chk_vec(8'(bar_color), 8'(COL_GREEN));
		conclude();
	end
endmodule // testbench
